//--- src/pdr_phase_range.sv
`timescale 1ns/1ns
module pdr_phase_range
  import pdr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ref_tick_i,
  input wire logic fb_tick_i,
  input wire logic signed [FRAC_W-1:0] fine_phase_i,
  output logic signed [ERR_W-1:0] phase_err_o,
  output logic phase_loss_o,
  output logic irq_o
);

  pdr_cfg_t cfg;
  pdr_cfg_t next_cfg;
  logic [STS_W-1:0] sts;
  logic [STS_W-1:0] next_sts;
  logic [STS_W-1:0] irq_en;
  logic [STS_W-1:0] next_irq_en;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic loss;
  logic next_loss;
  logic signed [ERR_W-1:0] err;
  logic signed [ERR_W-1:0] next_err;

  logic req;
  logic wr;
  logic cfg_wr;
  logic [UI_W-1:0] limit;
  // one bit past the 13-bit span so an overrun of the widest range still fits
  logic signed [UI_W:0] ui_count;
  logic [UI_W:0] ui_mag;
  logic ui_sat;
  logic signed [ERR_W-1:0] full_err;
  logic [STS_W-1:0] evt;

  // config byte to fields by bit position, bit 4 dropped
  function automatic pdr_cfg_t cfg_unpack(input logic [7:0] b);
    pdr_cfg_t c;
    c.loss_en = b[CFG_LOSS_EN_BIT];
    c.wide_en = b[CFG_WIDE_EN_BIT];
    c.multi_loop_resp = b[CFG_MULTI_BIT];
    c.range = b[CFG_RANGE_LSB +: 4];
    return c;
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !ack;
  // writes land on the ack edge, the one at which the master sees the answer
  assign wr = wb_cyc_i && wb_stb_i && ack && wb_we_i;
  assign cfg_wr = wr && (wb_adr_i == ADR_CONFIG) && wb_sel_i[0];
  assign limit = pdr_range_limit(cfg.range);

  // inactive tracker holds zero, so no multi-cycle history without wide range
  pdr_cycle_tracker #(
    .W(UI_W + 1)
  ) u_tracker (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(cfg.wide_en),
    .up_i(ref_tick_i),
    .dn_i(fb_tick_i),
    .limit_i({1'b0, limit}),
    .count_o(ui_count),
    .sat_o(ui_sat)
  );

  assign ui_mag = ui_count[UI_W] ? -ui_count : ui_count;
  // whole cycles plus fine fraction, fraction units of 1/256 UI
  assign full_err = {ui_count, {FRAC_W{1'b0}}}
    + {{(ERR_W-FRAC_W){fine_phase_i[FRAC_W-1]}}, fine_phase_i};
  assign evt = {ui_sat, next_loss && !loss};

  // loss and loop phase
  always_comb begin
    next_loss = cfg.loss_en && (ui_mag > limit);
    if (cfg.multi_loop_resp) begin
      next_err = full_err;
    end else if (full_err > ERR_ONE_UI) begin
      next_err = ERR_ONE_UI;
    end else if (full_err < -ERR_ONE_UI) begin
      next_err = -ERR_ONE_UI;
    end else begin
      next_err = full_err;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loss <= 1'b0;
      err <= '0;
    end else begin
      loss <= next_loss;
      err <= next_err;
    end
  end

  // wishbone register file
  always_comb begin
    next_cfg = cfg;
    next_irq_en = irq_en;
    next_sts = sts;
    next_ack = req;
    next_rdata = 32'h0000_0000;
    if (cfg_wr) begin
      next_cfg = cfg_unpack(wb_dat_i[7:0] & CFG_WR_MASK);
    end
    if (wr && (wb_adr_i == ADR_IRQ_EN) && wb_sel_i[0]) begin
      next_irq_en = wb_dat_i[STS_W-1:0];
    end
    if (wr && (wb_adr_i == ADR_IRQ_CLR) && wb_sel_i[0]) begin
      next_sts = sts & ~wb_dat_i[STS_W-1:0];
    end
    // a new event beats a clear in the same cycle
    next_sts = next_sts | evt;
    if (req && !wb_we_i) begin
      if (wb_adr_i == ADR_CONFIG) begin
        next_rdata = {24'h00_0000, cfg.loss_en, cfg.wide_en, cfg.multi_loop_resp,
          1'b0, cfg.range};
      end else if (wb_adr_i == ADR_STATUS) begin
        next_rdata = {{(32-STS_W){1'b0}}, sts};
      end else if (wb_adr_i == ADR_IRQ_EN) begin
        next_rdata = {{(32-STS_W){1'b0}}, irq_en};
      end else if (wb_adr_i == ADR_PHASE) begin
        next_rdata = {loss, 9'h000, ui_count, fine_phase_i};
      end else begin
        next_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= cfg_unpack(CFG_RESET);
      sts <= STS_RESET;
      irq_en <= IRQ_EN_RESET;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      sts <= next_sts;
      irq_en <= next_irq_en;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign phase_loss_o = loss;
  assign phase_err_o = err;
  assign irq_o = |(sts & irq_en);

  // checks
  AST_NO_LOSS_WHEN_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg.loss_en |=> !phase_loss_o)
    else $error("phase loss raised while loss detection disabled");

  AST_LOSS_ON_EXCESS: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg.loss_en && (ui_mag > limit)) |=> phase_loss_o)
    else $error("phase loss missed after error passed range");

  AST_WIDE_OFF_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg.wide_en |=> (ui_count == '0))
    else $error("cycle tracker active without wide range");

  AST_WIDE_TRACKS: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg.wide_en && !cfg_wr && ref_tick_i && !fb_tick_i && (ui_mag <= {1'b0, limit}))
      |=> (ui_count == $past(ui_count) + 14'sd1))
    else $error("tracker did not follow reference cycle");

  AST_FULL_PHASE: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg.multi_loop_resp |=> (phase_err_o == $past(full_err)))
    else $error("full coarse phase not passed to loop");

  AST_LIMITED: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cfg.multi_loop_resp && (full_err > ERR_ONE_UI)) |=> (phase_err_o == ERR_ONE_UI))
    else $error("loop phase not clamped to one cycle");

  AST_RETAIN: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cfg.multi_loop_resp && cfg.wide_en && !cfg_wr && !ref_tick_i && !fb_tick_i)
      [*3] |-> (ui_count == $past(ui_count)))
    else $error("tracked phase lost while response limited");

  AST_SPAN: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg.wide_en && !cfg_wr) |=> (ui_mag <= {1'b0, $past(limit)} + 14'd1))
    else $error("tracked phase beyond selected span");

  AST_TOP_CODES: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg.range > RANGE_TOP_CODE) |-> (limit == 13'd4095))
    else $error("upper range codes not widest span");

  AST_BIT4_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && (wb_adr_i == ADR_CONFIG)) |=> !wb_dat_o[CFG_UNUSED_BIT])
    else $error("unused config bit reads nonzero");

  COV_LOSS: cover property (@(posedge clk_i) disable iff (rst_i)
    !phase_loss_o ##1 phase_loss_o);
  COV_CLAMP: cover property (@(posedge clk_i) disable iff (rst_i)
    !cfg.multi_loop_resp && (full_err > ERR_ONE_UI));
  AST_TRACK_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg.wide_en && fb_tick_i && !ref_tick_i && (ui_mag <= {1'b0, limit}))
      |=> (ui_count == $past(ui_count) - 14'sd1))
    else $error("tracker did not follow feedback cycle");

  AST_CFG_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_wr |=> ((cfg.wide_en == $past(wb_dat_i[CFG_WIDE_EN_BIT]))
      && (cfg.multi_loop_resp == $past(wb_dat_i[CFG_MULTI_BIT]))))
    else $error("config write did not land in its fields");

  AST_LIMITED_NEG: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cfg.multi_loop_resp && (full_err < -ERR_ONE_UI)) |=> (phase_err_o == -ERR_ONE_UI))
    else $error("negative loop phase not clamped to one cycle");

  AST_LOSS_EVENT: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg.loss_en && (ui_mag > limit) && !phase_loss_o) |=> sts[STS_LOSS_BIT])
    else $error("phase loss did not set its status bit");

  AST_STS_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && (wb_adr_i == ADR_IRQ_CLR)) |=> ((sts & $past(sts)) == $past(sts)))
    else $error("status bit dropped without a clear");

  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");

  AST_ACK_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in the next cycle");

  COV_SAT_IRQ: cover property (@(posedge clk_i) disable iff (rst_i)
    ui_sat ##[1:4] irq_o);
  COV_TOP_RANGE: cover property (@(posedge clk_i) disable iff (rst_i)
    cfg.wide_en && (cfg.range > RANGE_TOP_CODE) && ref_tick_i);
  COV_LIMITED_NEG: cover property (@(posedge clk_i) disable iff (rst_i)
    !cfg.multi_loop_resp && (full_err < -ERR_ONE_UI));

endmodule

//--- src/pdr_pkg.sv
package pdr_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] ADR_CONFIG = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h08;
  localparam logic [7:0] ADR_IRQ_EN = 8'h0c;
  localparam logic [7:0] ADR_PHASE = 8'h10;

  // config field positions
  localparam int unsigned CFG_LOSS_EN_BIT = 7;
  localparam int unsigned CFG_WIDE_EN_BIT = 6;
  localparam int unsigned CFG_MULTI_BIT = 5;
  localparam int unsigned CFG_UNUSED_BIT = 4;
  localparam int unsigned CFG_RANGE_LSB = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WR_MASK = 8'hef;

  // status / interrupt bit positions
  localparam int unsigned STS_LOSS_BIT = 0;
  localparam int unsigned STS_SAT_BIT = 1;
  localparam int unsigned STS_W = 2;
  localparam logic [STS_W-1:0] STS_RESET = 2'h0;
  localparam logic [STS_W-1:0] IRQ_EN_RESET = 2'h0;

  // phase number formats
  localparam int unsigned UI_W = 13;
  localparam int unsigned FRAC_W = 8;
  localparam int unsigned ERR_W = 22;
  localparam logic [3:0] RANGE_TOP_CODE = 4'hb;
  // one whole UI, i.e. 360 degrees, in fraction units
  localparam logic signed [ERR_W-1:0] ERR_ONE_UI = 22'sh000100;

  typedef struct packed {
    logic loss_en;
    logic wide_en;
    logic multi_loop_resp;
    logic [3:0] range;
  } pdr_cfg_t;

  // tracked span in UI for a range code: 2^(k+1)-1, top codes saturate
  function automatic logic [UI_W-1:0] pdr_range_limit(input logic [3:0] code);
    logic [3:0] k;
    k = (code > RANGE_TOP_CODE) ? RANGE_TOP_CODE : code;
    return (13'h0002 << k) - 13'h0001;
  endfunction

endpackage

//--- src/pdr_cycle_tracker.sv
`timescale 1ns/1ns
module pdr_cycle_tracker
  import pdr_pkg::*;
#(
  parameter int unsigned W = UI_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic up_i,
  input wire logic dn_i,
  input wire logic [W-1:0] limit_i,
  output logic signed [W-1:0] count_o,
  output logic sat_o
);

  logic signed [W-1:0] count;
  logic signed [W-1:0] next_count;
  logic next_sat;
  logic sat;
  logic signed [W-1:0] bound;

  // one UI of headroom past the limit so an overrun is visible
  assign bound = $signed(limit_i + W'(1));

  always_comb begin
    next_count = count;
    next_sat = 1'b0;
    if (!enable_i) begin
      next_count = '0;
    end else if (count > bound) begin
      next_count = bound;
    end else if (count < -bound) begin
      next_count = -bound;
    end else if (up_i && !dn_i) begin
      if (count < bound) begin
        next_count = count + W'(1);
      end else begin
        next_sat = 1'b1;
      end
    end else if (dn_i && !up_i) begin
      if (count > -bound) begin
        next_count = count - W'(1);
      end else begin
        next_sat = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      sat <= 1'b0;
    end else begin
      count <= next_count;
      sat <= next_sat;
    end
  end

  assign count_o = count;
  assign sat_o = sat;

endmodule

//--- tb/pdr_phase_range_test.sv
`timescale 1ns/1ns
module pdr_phase_range_test;
  import pdr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdo, rd;
  logic ack, ref_t = 1'b0, fb_t = 1'b0, loss, irq;
  logic signed [FRAC_W-1:0] fine = 8'sh10;
  logic signed [ERR_W-1:0] perr;
  int bad_count = 0;
  int checked = 0;
  pdr_phase_range DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo),
    .wb_ack_o(ack), .ref_tick_i(ref_t), .fb_tick_i(fb_t), .fine_phase_i(fine),
    .phase_err_o(perr), .phase_loss_o(loss), .irq_o(irq));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic conclude();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; master never assumes the ack latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (n == 50) bad_count++;
    rd = rdo;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // n back-to-back pulses, then let count and phase error settle
  task automatic tick(input logic r, input logic f, input int n);
    repeat (n) begin
      @(posedge clk_i);
      ref_t <= r; fb_t <= f;
    end
    @(posedge clk_i);
    ref_t <= 1'b0; fb_t <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic t_reset();
    chk({10'h0, perr}, 32'h0);
    chk({30'h0, loss, irq}, 32'h0);
    rchk(ADR_CONFIG, 32'h0);
    rchk(ADR_STATUS, 32'h0);
    rchk(ADR_IRQ_EN, 32'h0);
    rchk(8'h40, 32'h0);
    wb(1'b1, ADR_CONFIG, 32'hff);
    rchk(ADR_CONFIG, 32'hef);
    $display("test reset done");
  endtask
  task automatic t_narrow();
    wb(1'b1, ADR_CONFIG, 32'h80);
    tick(1'b1, 1'b0, 3);
    chk({10'h0, perr}, 32'h10);
    chk({31'h0, loss}, 32'h0);
    $display("test narrow done");
  endtask
  task automatic t_multi();
    wb(1'b1, ADR_IRQ_EN, 32'h3);
    wb(1'b1, ADR_CONFIG, 32'he0);
    tick(1'b1, 1'b0, 1);
    chk({10'h0, perr}, 32'h110);
    chk({31'h0, loss}, 32'h0);
    tick(1'b1, 1'b0, 2);
    chk({31'h0, loss}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rchk(ADR_STATUS, 32'h3);
    rchk(ADR_PHASE, 32'h80000210);
    wb(1'b1, ADR_IRQ_CLR, 32'h3);
    rchk(ADR_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, ADR_CONFIG, 32'h60);
    tick(1'b0, 1'b0, 1);
    chk({31'h0, loss}, 32'h0);
    $display("test multi done");
  endtask
  task automatic t_limited();
    wb(1'b1, ADR_CONFIG, 32'h40);
    tick(1'b0, 1'b0, 1);
    chk({10'h0, perr}, 32'h100);
    rchk(ADR_PHASE, 32'h210);
    tick(1'b0, 1'b1, 4);
    chk({10'h0, perr}, 32'h3fff00);
    rchk(ADR_PHASE, 32'h3ffe10);
    $display("test limited done");
  endtask
  task automatic t_range();
    wb(1'b1, ADR_CONFIG, 32'h6f);
    tick(1'b1, 1'b1, 2);
    tick(1'b1, 1'b0, 5);
    rchk(ADR_PHASE, 32'h310);
    wb(1'b1, ADR_CONFIG, 32'h60);
    tick(1'b0, 1'b0, 1);
    rchk(ADR_PHASE, 32'h210);
    $display("test range done");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_narrow();
    t_multi();
    t_limited();
    t_range();
    conclude();
  end
  // sized well past the hundred or so cycles the tests need
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
endmodule
